// ==== inc/gpib_port_defs.vh ====
// constants for the instrument-side bus port
// assumes a 50 MHz system clock and active-high bus lines at the pins
`ifndef GPIB_PORT_DEFS_VH
`define GPIB_PORT_DEFS_VH
// configuration switch field positions
`define CFG_ADDR_LSB 0
`define CFG_ADDR_MSB 4
`define CFG_DELIM_BIT 5
`define CFG_EOI_BIT 6
`define CFG_ADDR_MAX 5'h1e
// multiline command bytes (attention asserted), low seven bits
`define CMD_GTL 7'h01
`define CMD_SDC 7'h04
`define CMD_GET 7'h08
`define CMD_LLO 7'h11
`define CMD_DCL 7'h14
`define CMD_SPE 7'h18
`define CMD_SPD 7'h19
`define CMD_LAG_BASE 7'h20
`define CMD_UNL 7'h3f
`define CMD_TAG_BASE 7'h40
`define CMD_UNT 7'h5f
// delimiter characters
`define CHR_COMMA 8'h2c
`define CHR_CR 8'h0d
`define CHR_LF 8'h0a
// settling time before data valid is asserted, ns, and cycles at 50 MHz
`define SETTLE_NS 2000
`define CLK_NS 20
`define SETTLE_CYC ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// ==== hw/gpib_sync.v ====
// two-flop synchroniser for a group of bus pins
// assumes inputs are asynchronous to clk_i
`timescale 1ns/1ps
module gpib_sync #(
    parameter WIDTH = 8
) (
    input wire clk_i,
    input wire sys_rst_i,
    input wire [WIDTH-1:0] async_i,
    output reg [WIDTH-1:0] sync_o
);
reg [WIDTH-1:0] meta;
// first stage feeds only the second
always @(posedge clk_i)
begin
    if (sys_rst_i)
    begin
        meta <= {WIDTH{1'b0}};
        sync_o <= {WIDTH{1'b0}};
    end
    else
    begin
        meta <= async_i;
        sync_o <= meta;
    end
end
endmodule // gpib_sync

// ==== hw/gpib_instrument_port.v ====
// instrument-side bus port: handshakes, addressing, remote/local, panel lamps
// assumes bus lines arrive active high and are synchronised here; open-drain
// lines are driven by the board from the *_oe_o outputs
// Behaviour
// - no controller: talk-only source, unaddressed
// - service lamp lit while driving SRQ
// - listen and talk lamps follow addressing
// - remote lamp lit while under remote
// - local key returns to local control
// - lockout makes local key ignored
// - overlay graphics mode forces local lockout
// - address from switches one to five
// - switch six picks comma or CR/LF
// - switch seven enables EOI on last byte
// - show switch settings at power-up
// - listener drops when addressed to talk
// - remote/local, clear, trigger, end message
// - device clear returns display to menu
// - illegal paging raises service request
`timescale 1ns/1ps
`include "gpib_port_defs.vh"
module gpib_instrument_port #(
    parameter SETTLE_CYCLES = `SETTLE_CYC
) (
    input wire clk_i,
    input wire sys_rst_i,
    input wire [6:0] cfg_switch_i,
    input wire talk_only_i,
    input wire local_key_i,
    input wire overlay_graphics_mode_i,
    input wire paging_error_i,
    input wire service_clear_i,
    input wire [7:0] dio_i,
    input wire dav_i,
    input wire nrfd_i,
    input wire ndac_i,
    input wire atn_i,
    input wire ren_i,
    input wire ifc_i,
    input wire [7:0] tx_data_i,
    input wire tx_last_i,
    input wire tx_valid_i,
    output wire tx_ready_o,
    output reg [7:0] rx_data_o,
    output reg rx_valid_o,
    output reg [7:0] dio_o,
    output reg dio_oe_o,
    output reg dav_oe_o,
    output reg eoi_oe_o,
    output reg nrfd_oe_o,
    output reg ndac_oe_o,
    output reg srq_oe_o,
    output reg lamp_srq_o,
    output reg lamp_listen_o,
    output reg lamp_talk_o,
    output reg lamp_remote_o,
    output reg [6:0] cfg_show_o,
    output reg cfg_show_valid_o,
    output reg [4:0] bus_addr_o,
    output reg delim_crlf_o,
    output reg eoi_enable_o,
    output reg device_clear_o,
    output reg trigger_o,
    output reg goto_menu_o
);
// source handshake states
localparam SRC_IDLE = 4'b0001;
localparam SRC_SETTLE = 4'b0010;
localparam SRC_WAIT = 4'b0100;
localparam SRC_DONE = 4'b1000;
// acceptor handshake states
localparam ACC_READY = 3'b001;
localparam ACC_TAKE = 3'b010;
localparam ACC_HOLD = 3'b100;

wire [7:0] dio_s;
wire [5:0] ctl_s;
wire [1:0] key_s;
wire dav_s, nrfd_s, ndac_s, atn_s, ren_s, ifc_s, lkey_s, tonly_s;
reg [3:0] src_st;
reg [2:0] acc_st;
reg [11:0] settle_cnt;
reg cfg_taken, listen, talk, remote, lockout, spoll, key_q;
reg [7:0] tx_byte;
reg tx_eoi;

gpib_sync #(.WIDTH(8)) u_sync_dio (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i(dio_i),
    .sync_o(dio_s)
);
gpib_sync #(.WIDTH(6)) u_sync_ctl (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({dav_i, nrfd_i, ndac_i, atn_i, ren_i, ifc_i}),
    .sync_o(ctl_s)
);
gpib_sync #(.WIDTH(2)) u_sync_key (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .async_i({local_key_i, talk_only_i}),
    .sync_o(key_s)
);
assign {dav_s, nrfd_s, ndac_s, atn_s, ren_s, ifc_s} = ctl_s;
assign {lkey_s, tonly_s} = key_s;

// talker may source only outside command phase
wire talk_active = (talk | tonly_s) & ~atn_s;
assign tx_ready_o = talk_active & (src_st == SRC_IDLE);

// sample switches once after reset; hold until next reset
always @(posedge clk_i)
begin
    if (sys_rst_i)
    begin
        cfg_taken <= 1'b0;
        bus_addr_o <= 5'h00;
        delim_crlf_o <= 1'b0;
        eoi_enable_o <= 1'b0;
        cfg_show_o <= 7'h00;
        cfg_show_valid_o <= 1'b0;
    end
    else if (!cfg_taken)
    begin
        cfg_taken <= 1'b1;
        bus_addr_o <= cfg_switch_i[`CFG_ADDR_MSB:`CFG_ADDR_LSB];
        delim_crlf_o <= cfg_switch_i[`CFG_DELIM_BIT];
        eoi_enable_o <= cfg_switch_i[`CFG_EOI_BIT];
        cfg_show_o <= cfg_switch_i;
        cfg_show_valid_o <= 1'b1;
    end
end

// acceptor handshake; commands are taken under attention even when
// not addressed, data only while addressed to listen
wire acc_on = atn_s | listen;
wire [6:0] cmd = dio_s[6:0];
wire own_addr = (bus_addr_o <= `CFG_ADDR_MAX);
wire my_lag = own_addr && cmd == (`CMD_LAG_BASE | {2'b00, bus_addr_o});
wire my_tag = own_addr && cmd == (`CMD_TAG_BASE | {2'b00, bus_addr_o});
always @(posedge clk_i)
begin
    if (sys_rst_i)
    begin
        acc_st <= ACC_READY;
        nrfd_oe_o <= 1'b0;
        ndac_oe_o <= 1'b0;
        listen <= 1'b0;
        talk <= 1'b0;
        spoll <= 1'b0;
        lockout <= 1'b0;
        rx_data_o <= 8'h00;
        rx_valid_o <= 1'b0;
        device_clear_o <= 1'b0;
        trigger_o <= 1'b0;
        goto_menu_o <= 1'b0;
    end
    else
    begin
        rx_valid_o <= 1'b0;
        device_clear_o <= 1'b0;
        trigger_o <= 1'b0;
        goto_menu_o <= 1'b0;
        if (overlay_graphics_mode_i)
            lockout <= 1'b1;
        if (ifc_s)
        begin
            listen <= 1'b0;
            talk <= 1'b0;
            spoll <= 1'b0;
        end
        if (!ren_s)
            lockout <= overlay_graphics_mode_i;
        case (acc_st)
            ACC_READY:
            begin
                ndac_oe_o <= acc_on;
                nrfd_oe_o <= 1'b0;
                if (acc_on && dav_s)
                begin
                    nrfd_oe_o <= 1'b1;
                    acc_st <= ACC_TAKE;
                end
            end
            ACC_TAKE:
            begin
                if (atn_s)
                begin
                    if (my_lag)
                    begin
                        listen <= 1'b1;
                        talk <= 1'b0;
                    end
                    else if (cmd == `CMD_UNL)
                        listen <= 1'b0;
                    else if (my_tag)
                    begin
                        talk <= 1'b1;
                        listen <= 1'b0;
                    end
                    else if (cmd[6:5] == 2'b10)
                        talk <= 1'b0;
                    else if (cmd == `CMD_LLO)
                        lockout <= 1'b1;
                    else if (cmd == `CMD_DCL ||
                             (cmd == `CMD_SDC && listen))
                    begin
                        device_clear_o <= 1'b1;
                        goto_menu_o <= 1'b1;
                    end
                    else if (cmd == `CMD_GET && listen)
                        trigger_o <= 1'b1;
                    else if (cmd == `CMD_SPE)
                        spoll <= 1'b1;
                    else if (cmd == `CMD_SPD)
                        spoll <= 1'b0;
                end
                else
                begin
                    rx_data_o <= dio_s;
                    rx_valid_o <= 1'b1;
                end
                ndac_oe_o <= 1'b0;
                acc_st <= ACC_HOLD;
            end
            default:
            begin
                // wait for source to drop data valid before rearming
                if (!dav_s)
                begin
                    ndac_oe_o <= acc_on;
                    acc_st <= ACC_READY;
                end
            end
        endcase
    end
end

// remote/local: remote asserted by addressing with REN, local key
// honoured only without lockout
always @(posedge clk_i)
begin
    if (sys_rst_i)
    begin
        remote <= 1'b0;
        key_q <= 1'b0;
    end
    else
    begin
        key_q <= lkey_s;
        if (!ren_s)
            remote <= 1'b0;
        else if (acc_st == ACC_TAKE && atn_s && my_lag)
            remote <= 1'b1;
        else if (acc_st == ACC_TAKE && atn_s && listen &&
                 cmd == `CMD_GTL && !lockout)
            remote <= 1'b0;
        else if (lkey_s && !key_q && !lockout)
            remote <= 1'b0;
        else if (lockout)
            remote <= 1'b1;
    end
end

// source handshake; status byte during serial poll, else user data
always @(posedge clk_i)
begin
    if (sys_rst_i)
    begin
        src_st <= SRC_IDLE;
        dio_o <= 8'h00;
        dio_oe_o <= 1'b0;
        dav_oe_o <= 1'b0;
        eoi_oe_o <= 1'b0;
        settle_cnt <= 12'h000;
        tx_byte <= 8'h00;
        tx_eoi <= 1'b0;
    end
    else
    begin
        case (src_st)
            SRC_IDLE:
            begin
                dav_oe_o <= 1'b0;
                eoi_oe_o <= 1'b0;
                dio_oe_o <= 1'b0;
                if (talk_active && spoll)
                begin
                    tx_byte <= {1'b0, srq_oe_o, 6'h00};
                    tx_eoi <= 1'b0;
                    src_st <= SRC_SETTLE;
                end
                else if (talk_active && tx_valid_i)
                begin
                    tx_byte <= tx_data_i;
                    tx_eoi <= tx_last_i & eoi_enable_o;
                    src_st <= SRC_SETTLE;
                end
                settle_cnt <= SETTLE_CYCLES[11:0];
            end
            SRC_SETTLE:
            begin
                dio_o <= tx_byte;
                dio_oe_o <= 1'b1;
                eoi_oe_o <= tx_eoi;
                if (atn_s)
                    src_st <= SRC_IDLE;
                else if (settle_cnt != 12'h000)
                    settle_cnt <= settle_cnt - 12'h001;
                else if (!nrfd_s)
                begin
                    dav_oe_o <= 1'b1;
                    src_st <= SRC_WAIT;
                end
            end
            SRC_WAIT:
            begin
                if (atn_s || !ndac_s)
                begin
                    dav_oe_o <= 1'b0;
                    src_st <= SRC_DONE;
                end
            end
            default:
            begin
                // serial poll byte is sent once per poll
                dio_oe_o <= 1'b0;
                eoi_oe_o <= 1'b0;
                if (!spoll || atn_s)
                    src_st <= SRC_IDLE;
            end
        endcase
    end
end

// service request held until cleared; set wins over clear
always @(posedge clk_i)
begin
    if (sys_rst_i)
        srq_oe_o <= 1'b0;
    else if (paging_error_i)
        srq_oe_o <= 1'b1;
    else if (service_clear_i)
        srq_oe_o <= 1'b0;
end

// front-panel lamps mirror the state registers
always @(posedge clk_i)
begin
    if (sys_rst_i)
    begin
        lamp_srq_o <= 1'b0;
        lamp_listen_o <= 1'b0;
        lamp_talk_o <= 1'b0;
        lamp_remote_o <= 1'b0;
    end
    else
    begin
        lamp_srq_o <= srq_oe_o;
        lamp_listen_o <= listen;
        lamp_talk_o <= talk | tonly_s;
        lamp_remote_o <= remote;
    end
end
endmodule // gpib_instrument_port

// ==== testbench/ieee_port_properties.sv ====
// checker for the instrument bus port: handshake, lamps, switch capture
// assumes one clock domain; bound onto the port's own ports
`timescale 1ns/1ps
module ieee_port_checker #(
    parameter SETTLE_CYCLES = 2
) (
    input wire clk_i,
    input wire sys_rst_i,
    input wire ren_i,
    input wire dav_i,
    input wire ndac_i,
    input wire paging_error_i,
    input wire [7:0] dio_o,
    input wire dio_oe_o,
    input wire dav_oe_o,
    input wire nrfd_oe_o,
    input wire srq_oe_o,
    input wire lamp_srq_o,
    input wire lamp_listen_o,
    input wire lamp_talk_o,
    input wire lamp_remote_o,
    input wire rx_valid_o,
    input wire [6:0] cfg_show_o,
    input wire cfg_show_valid_o,
    input wire [4:0] bus_addr_o,
    input wire delim_crlf_o,
    input wire eoi_enable_o
);
    // one domain, so clock and reset are given once
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_srq_lamp_on: assert property (srq_oe_o [*2] |-> lamp_srq_o)
        else $error("srq lamp dark");
    a_paging_raises_srq: assert property (paging_error_i |-> ##[1:4] srq_oe_o)
        else $error("srq not raised");
    a_dav_drop_ndac: assert property ((dav_oe_o && !ndac_i) |-> ##[1:5] !dav_oe_o)
        else $error("data valid held");
    a_dio_hold: assert property (dav_oe_o |-> dio_oe_o && $stable(dio_o))
        else $error("data moved");
    a_nrfd_hold: assert property ((nrfd_oe_o && dav_i) |=> nrfd_oe_o)
        else $error("not ready dropped");
    a_lamp_excl: assert property (!(lamp_talk_o && lamp_listen_o))
        else $error("talk and listen");
    a_cfg_fields: assert property (cfg_show_valid_o |-> bus_addr_o ==
        cfg_show_o[4:0] && delim_crlf_o == cfg_show_o[5] &&
        eoi_enable_o == cfg_show_o[6])
        else $error("switch fields");
    a_remote_ren: assert property ((!ren_i) [*6] |-> !lamp_remote_o)
        else $error("remote without ren");
    c_talk: cover property ($rose(lamp_talk_o));
    c_rx: cover property ($rose(rx_valid_o));
    c_local: cover property ($fell(lamp_remote_o));
endmodule // ieee_port_checker

bind gpib_instrument_port ieee_port_checker #(
    .SETTLE_CYCLES(SETTLE_CYCLES)) chk_i (.clk_i, .sys_rst_i, .ren_i,
    .dav_i, .ndac_i, .paging_error_i, .dio_o, .dio_oe_o, .dav_oe_o,
    .nrfd_oe_o, .srq_oe_o, .lamp_srq_o, .lamp_listen_o, .lamp_talk_o,
    .lamp_remote_o, .rx_valid_o, .cfg_show_o, .cfg_show_valid_o,
    .bus_addr_o, .delim_crlf_o, .eoi_enable_o);

// ==== testbench/ieee_ctl_model.sv ====
// bus controller model: sends bytes with a source handshake, accepts
// talker bytes; released lines read 0, the unasserted level
`timescale 1ns/1ps
module ieee_ctl_model (
    input wire clk_i,
    input wire [7:0] dio_i,
    input wire dav_i,
    input wire nrfd_i,
    input wire ndac_i,
    input wire eoi_i,
    input wire lsn_i,
    input wire stall_i,
    output logic [7:0] dio_o = 8'h00,
    output logic dav_o = 1'h0,
    output logic atn_o = 1'h0,
    output logic nrfd_o = 1'h0,
    output logic ndac_o = 1'h0
);
    logic [7:0] got = 8'h00;
    logic got_eoi = 1'h0;
    int got_cnt = 0;
    int fails = 0;
    // acceptor; a stall holds not-ready to make the port wait
    always @(posedge clk_i)
    begin
        if (!lsn_i)
        begin
            nrfd_o <= 1'h0;
            ndac_o <= 1'h0;
        end
        else if (dav_i && ndac_o)
        begin
            nrfd_o <= 1'h1;
            ndac_o <= 1'h0;
            got <= dio_i;
            got_eoi <= eoi_i;
            got_cnt <= got_cnt + 1;
        end
        else if (!dav_i)
        begin
            nrfd_o <= stall_i;
            ndac_o <= 1'h1;
        end
    end
    // source handshake; attention and byte go out first so acceptors
    // can answer, data valid only once they are ready; a stuck line
    // is counted, not waited on forever
    task automatic send(input logic [7:0] b, input logic atn);
        int n;
        dio_o <= b;
        atn_o <= atn;
        @(posedge clk_i);
        for (n = 0; n < 200 && (nrfd_i || !ndac_i); n++)
            @(posedge clk_i);
        fails += (n == 200);
        dav_o <= 1'h1;
        @(posedge clk_i);
        for (n = 0; n < 200 && ndac_i; n++)
            @(posedge clk_i);
        fails += (n == 200);
        dav_o <= 1'h0;
        dio_o <= 8'h00;
        atn_o <= 1'h0;
    endtask
endmodule // ieee_ctl_model

// ==== testbench/tb.sv ====
// self-checking bench for the instrument bus port
// assumes the controller model and the bound checker beside it
`timescale 1ns/1ps
module tb;
    logic clk_i = 1'h0, sys_rst_i = 1'h1, talk_only_i = 1'h0;
    logic local_key_i = 1'h0, overlay_graphics_mode_i = 1'h0;
    logic paging_error_i = 1'h0, service_clear_i = 1'h0, ren_i = 1'h0;
    logic ifc_i = 1'h0, tx_last_i = 1'h0, tx_valid_i = 1'h0;
    logic lsn = 1'h0, stall = 1'h0;
    logic [6:0] cfg_switch_i = 7'h45;
    logic [7:0] tx_data_i = 8'h00, rx_last = 8'h00;
    int error_cnt = 0, samples_checked = 0, cyc = 0;
    int n_trig = 0, n_clr = 0, n_menu = 0;
    wire [7:0] rx_data_o, dio_o, c_dio;
    wire [6:0] cfg_show_o;
    wire [4:0] bus_addr_o;
    wire tx_ready_o, rx_valid_o, dio_oe_o, dav_oe_o, eoi_oe_o, nrfd_oe_o;
    wire ndac_oe_o, srq_oe_o, lamp_srq_o, lamp_listen_o, lamp_talk_o;
    wire lamp_remote_o, cfg_show_valid_o, delim_crlf_o, eoi_enable_o;
    wire device_clear_o, trigger_o, goto_menu_o, c_dav, c_nrfd, c_ndac;
    wire atn_i;
    // open-collector wires: any party asserting wins
    wire [7:0] dio_i = (dio_oe_o ? dio_o : 8'h00) | c_dio;
    wire dav_i = dav_oe_o | c_dav;
    wire nrfd_i = nrfd_oe_o | c_nrfd;
    wire ndac_i = ndac_oe_o | c_ndac;

    gpib_instrument_port #(.SETTLE_CYCLES(2)) gpib_instrument_port_i (
        .clk_i, .sys_rst_i, .cfg_switch_i, .talk_only_i, .local_key_i,
        .overlay_graphics_mode_i, .paging_error_i, .service_clear_i,
        .dio_i, .dav_i, .nrfd_i, .ndac_i, .atn_i, .ren_i, .ifc_i,
        .tx_data_i, .tx_last_i, .tx_valid_i, .tx_ready_o, .rx_data_o,
        .rx_valid_o, .dio_o, .dio_oe_o, .dav_oe_o, .eoi_oe_o, .nrfd_oe_o,
        .ndac_oe_o, .srq_oe_o, .lamp_srq_o, .lamp_listen_o, .lamp_talk_o,
        .lamp_remote_o, .cfg_show_o, .cfg_show_valid_o, .bus_addr_o,
        .delim_crlf_o, .eoi_enable_o, .device_clear_o, .trigger_o,
        .goto_menu_o);
    ieee_ctl_model ctl_i (.clk_i, .dio_i, .dav_i, .nrfd_i, .ndac_i,
        .eoi_i(eoi_oe_o), .lsn_i(lsn), .stall_i(stall), .dio_o(c_dio),
        .dav_o(c_dav), .atn_o(atn_i), .nrfd_o(c_nrfd), .ndac_o(c_ndac));

    always #10 clk_i = ~clk_i;
    // pulses last one cycle, so count them; a hang ends the run
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        n_trig <= n_trig + trigger_o;
        n_clr <= n_clr + device_clear_o;
        n_menu <= n_menu + goto_menu_o;
        if (rx_valid_o)
            rx_last <= rx_data_o;
        if (cyc == 20000)
        begin
            error_cnt++;
            finish_test;
        end
    end

    task chk(input logic [7:0] exp, input logic [7:0] act);
        samples_checked++;
        if (exp !== act)
        begin
            error_cnt++;
            $display("Error at %0t: expected %h got %h", $time, exp, act);
        end
    endtask
    task w(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    task cmd(input logic [7:0] b, input logic a);
        ctl_i.send(b, a);
        w(4);
    endtask
    task press;
        local_key_i <= 1'h1;
        w(4);
        local_key_i <= 1'h0;
        w(6);
    endtask
    // offer a byte, hold it until taken, then wait for the controller
    task tx(input logic [7:0] d, input logic last, input logic eoi);
        int n;
        tx_data_i <= d;
        tx_last_i <= last;
        tx_valid_i <= 1'h1;
        n = ctl_i.got_cnt;
        // ready is read at the edge, so valid drops only once taken
        for (int k = 0; k < 50; k++)
        begin
            @(posedge clk_i);
            if (tx_ready_o === 1'h1)
                break;
        end
        tx_valid_i <= 1'h0;
        for (int k = 0; k < 300 && ctl_i.got_cnt == n; k++)
            @(posedge clk_i);
        chk(d, ctl_i.got);
        chk(8'(eoi), 8'(ctl_i.got_eoi));
    endtask
    task finish_test;
        $display("compares %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial
    begin
        w(2);
        sys_rst_i <= 1'h0;
        ren_i <= 1'h1;
        w(4);
        chk(8'h45, 8'(cfg_show_o));
        chk(8'h01, 8'(cfg_show_valid_o));
        cfg_switch_i <= 7'h3a;
        w(4);
        chk(8'h05, 8'(bus_addr_o));
        chk(8'h00, 8'(delim_crlf_o));
        $display("switch test done");
        cmd(8'h26, 1'h1);
        chk(8'h00, 8'(lamp_listen_o));
        cmd(8'h25, 1'h1);
        chk(8'h01, 8'(lamp_listen_o));
        chk(8'h01, 8'(lamp_remote_o));
        cmd(8'h37, 1'h0);
        chk(8'h37, rx_last);
        cmd(8'h08, 1'h1);
        cmd(8'h04, 1'h1);
        chk(8'h01, 8'(n_trig));
        chk(8'h01, 8'(n_clr));
        $display("listen test done");
        cmd(8'h45, 1'h1);
        chk(8'h01, 8'(lamp_talk_o));
        chk(8'h00, 8'(lamp_listen_o));
        lsn <= 1'h1;
        tx(8'ha5, 1'h1, 1'h1);
        stall <= 1'h1;
        fork
            tx(8'h5a, 1'h0, 1'h0);
            begin
                w(20);
                chk(8'h00, 8'(dav_oe_o));
                stall <= 1'h0;
            end
        join
        lsn <= 1'h0;
        cmd(8'h25, 1'h1);
        chk(8'h00, 8'(lamp_talk_o));
        $display("talk test done");
        press;
        chk(8'h00, 8'(lamp_remote_o));
        cmd(8'h25, 1'h1);
        cmd(8'h01, 1'h1);
        chk(8'h00, 8'(lamp_remote_o));
        cmd(8'h25, 1'h1);
        cmd(8'h11, 1'h1);
        press;
        chk(8'h01, 8'(lamp_remote_o));
        ren_i <= 1'h0;
        w(8);
        chk(8'h00, 8'(lamp_remote_o));
        ren_i <= 1'h1;
        cmd(8'h25, 1'h1);
        overlay_graphics_mode_i <= 1'h1;
        w(2);
        press;
        chk(8'h01, 8'(lamp_remote_o));
        overlay_graphics_mode_i <= 1'h0;
        cmd(8'h01, 1'h1);
        chk(8'h01, 8'(lamp_remote_o));
        cmd(8'h14, 1'h1);
        chk(8'h02, 8'(n_clr));
        chk(8'h02, 8'(n_menu));
        $display("remote test done");
        paging_error_i <= 1'h1;
        service_clear_i <= 1'h1;
        w(1);
        paging_error_i <= 1'h0;
        service_clear_i <= 1'h0;
        w(3);
        chk(8'h01, 8'(srq_oe_o));
        chk(8'h01, 8'(lamp_srq_o));
        // serial poll while service is requested: status bit six set
        cmd(8'h18, 1'h1);
        lsn <= 1'h1;
        cmd(8'h45, 1'h1);
        w(10);
        chk(8'h40, ctl_i.got);
        lsn <= 1'h0;
        cmd(8'h19, 1'h1);
        ifc_i <= 1'h1;
        w(6);
        chk(8'h00, 8'(lamp_talk_o));
        ifc_i <= 1'h0;
        service_clear_i <= 1'h1;
        w(1);
        service_clear_i <= 1'h0;
        w(3);
        chk(8'h00, 8'(lamp_srq_o));
        $display("service test done");
        sys_rst_i <= 1'h1;
        w(2);
        sys_rst_i <= 1'h0;
        w(4);
        chk(8'h1a, 8'(bus_addr_o));
        chk(8'h01, 8'(delim_crlf_o));
        talk_only_i <= 1'h1;
        lsn <= 1'h1;
        w(4);
        tx(8'hc3, 1'h1, 1'h0);
        chk(8'h00, 8'(ctl_i.fails));
        $display("talk only test done");
        finish_test;
    end
endmodule // tb
